//--- design/bert_pkg.sv
// Package with register map, field layouts and types of the pattern tester counters.
package bert_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [11:0] ADDR_CONTROL = 12'h500;
  localparam logic [11:0] ADDR_PAT_LOW = 12'h508;
  localparam logic [11:0] ADDR_PAT_HIGH = 12'h50C;
  localparam logic [11:0] ADDR_BIT_LOW = 12'h510;
  localparam logic [11:0] ADDR_BIT_HIGH = 12'h514;
  localparam logic [11:0] ADDR_ERR_STATUS = 12'h518;
  localparam logic [11:0] ADDR_ERR_HIGH = 12'h51C;

  // Reset values.
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] PATTERN_RESET = 16'h0000;

  // Status bit positions in the error count low and status register.
  localparam int STAT_SYNC = 0;
  localparam int STAT_ECO = 1;
  localparam int STAT_BCO = 2;
  localparam int STAT_BED = 3;
  localparam int STAT_LOS = 4;
  localparam int STAT_RA0 = 5;
  localparam int STAT_RA1 = 6;
  localparam int STAT_ERR_LSB = 8;

  // Synchronizer figures.
  localparam logic [5:0] LOCK_RUN = 6'h20;
  localparam logic [6:0] ERR_WINDOW = 7'h40;
  localparam logic [2:0] ERR_LIMIT = 3'h6;
  localparam logic [4:0] ALL_SAME_RUN = 5'h1F;

  // Pattern select codes.
  typedef enum logic [2:0] {
    PAT_PRBS7 = 3'b000,
    PAT_PRBS11 = 3'b001,
    PAT_PRBS15 = 3'b010,
    PAT_QRSS = 3'b011,
    PAT_REPEAT = 3'b100,
    PAT_ALTWORD = 3'b101,
    PAT_ILL6 = 3'b110,
    PAT_ILL7 = 3'b111
  } pat_sel_e;

  // Synchronizer states.
  typedef enum logic [0:0] {
    SYNC_SEARCH = 1'b0,
    SYNC_LOCKED = 1'b1
  } sync_e;

  // Control register layout, bit 15 first.
  typedef struct packed {
    logic lockChangeIrqEnable;
    logic bitErrorIrqEnable;
    logic overflowIrqEnable;
    logic spare12;
    logic [3:0] repLength;
    logic spare7;
    logic txInvert;
    logic rxInvert;
    pat_sel_e patternSelect;
    logic counterLoadStrobe;
    logic resync;
  } ctrl_s;

  // Latched status flags.
  typedef struct packed {
    logic allOnes;
    logic allZeros;
    logic lossOfLock;
    logic bitError;
    logic bitOverflow;
    logic errOverflow;
  } flags_s;

endpackage : bert_pkg

//--- design/bert_pattern_counters_status.sv
// Receive pattern checker with bit and error counters, status flags and APB registers.
//
// Functional notes
// - Pattern bits used least significant first.
// - Alternating mode swaps lower and upper words.
// - Bit counter counts every received bit.
// - Counters keep running when out of lock.
// - Load strobe rise snapshots counts for host.
// - Bit counter saturates and flags overflow.
// - Error counter counts mismatched bits.
// - Error counter saturates and flags overflow.
// - Lock after 32 matching bits in row.
// - Six errors in 64 bits drop lock.
// - Error overflow flag latched, read clears.
// - Bit overflow flag latched, read clears.
// - Bit error flag latched only in lock.
// - Loss flag set on search, read clears.
// - All zeros flag after 31 zeros.
// - All ones flag after 31 ones.
// - Error count split across two registers.
// - Bit count read as two words.
// - Load strobe rise also restarts internal counts.
// - Select field picks pattern, illegal codes.
// - Enables gate overflow, error, lock events.
`timescale 1ns/1ps

module bert_pattern_counters_status #(
  parameter int ALT_REPEAT = 1
) (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received bit stream from the assigned port.
  input wire logic rxClk,
  input wire logic rxData,
  // Event request gated by the enable bits.
  output logic testerAlert,
  // Unlatched lock indicator.
  output logic syncLocked
);
  import bert_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage.

  ctrl_s control_q; // Control register.
  logic [31:0] pattern_q; // Pattern store, bit 0 sent and compared first.
  logic [31:0] bitSnap_q; // Host copy of the bit count.
  logic [23:0] errSnap_q; // Host copy of the error count.
  flags_s flags_q; // Latched status flags.
  logic lockChange_q; // Sticky change of lock state.
  logic [31:0] prdata_q; // Read data captured in the setup cycle.
  logic [5:0] readMask_q; // Flags shown by the status read in progress.

  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable;
  wire wrDone = accessDone & pwrite;
  wire statusRead = accessDone & ~pwrite & (paddr == ADDR_ERR_STATUS);

  // Address decode; anything outside the map answers with an error.
  logic mapped;
  always_comb
  begin
    case (paddr)
      ADDR_CONTROL, ADDR_PAT_LOW, ADDR_PAT_HIGH, ADDR_BIT_LOW,
      ADDR_BIT_HIGH, ADDR_ERR_STATUS, ADDR_ERR_HIGH: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Zero wait state slave; read data is already in a flop by the access phase.
  assign pready = 1'b1;
  assign pslverr = accessDone & ~mapped;
  assign prdata = prdata_q;

  // Control and pattern writes; read only registers ignore writes.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      control_q <= ctrl_s'(CONTROL_RESET);
      pattern_q <= {PATTERN_RESET, PATTERN_RESET};
    end
    else if (wrDone)
    begin
      if (paddr == ADDR_CONTROL)
        control_q <= ctrl_s'(pwdata[15:0]);
      if (paddr == ADDR_PAT_LOW)
        pattern_q[15:0] <= pwdata[15:0];
      if (paddr == ADDR_PAT_HIGH)
        pattern_q[31:16] <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link sampling: the bit clock is foreign, so it and the data pass two flops.

  logic [2:0] clkSync_q; // Bit clock synchroniser plus edge history.
  logic [1:0] datSync_q; // Data synchroniser.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      clkSync_q <= 3'h0;
      datSync_q <= 2'h0;
    end
    else
    begin
      clkSync_q <= {clkSync_q[1:0], rxClk};
      datSync_q <= {datSync_q[0], rxData};
    end
  end

  // Rising bit clock edge marks one received bit; optional inversion applied.
  wire bitStrobe = clkSync_q[1] & ~clkSync_q[2];
  wire rxBit = datSync_q[1] ^ control_q.rxInvert;

  ////////////////////////////////////////////////////////////////////////////////
  // Expected pattern and synchronizer.

  sync_e syncState_q; // Search or locked.
  logic [6:0] prbs_q; // Pseudorandom generator state.
  logic [4:0] patPtr_q; // Bit index into the pattern store.
  logic wordSel_q; // Upper word active in alternating mode.
  logic [7:0] wordRep_q; // Words sent of the current alternating half.
  logic [5:0] matchRun_q; // Consecutive matches while searching.
  logic [6:0] winCnt_q; // Bits seen in the current error window.
  logic [2:0] winErr_q; // Errors seen in the current error window.
  logic resyncPrev_q; // Previous resync bit for edge detection.
  logic expBit; // Expected bit now.
  logic modeOk; // Select code supported by this checker.

  // The chosen code picks the source of the expected bit.
  always_comb
  begin
    expBit = 1'b0;
    modeOk = 1'b1;
    case (control_q.patternSelect)
      PAT_PRBS7: expBit = prbs_q[6] ^ prbs_q[5];
      PAT_REPEAT: expBit = pattern_q[patPtr_q];
      PAT_ALTWORD: expBit = pattern_q[{wordSel_q, patPtr_q[3:0]}];
      default: modeOk = 1'b0;
    endcase
  end

  wire mismatch = rxBit ^ expBit;
  wire resyncRise = control_q.resync & ~resyncPrev_q;
  wire lockGain = bitStrobe && syncState_q == SYNC_SEARCH && modeOk && !mismatch
    && matchRun_q == LOCK_RUN - 6'h01;
  wire lockLose = bitStrobe && syncState_q == SYNC_LOCKED && mismatch
    && winErr_q == ERR_LIMIT - 3'h1;
  wire searchStart = resyncRise | lockLose;

  // Lock state: 32 matches lock, six errors in a 64 bit window unlock.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      syncState_q <= SYNC_SEARCH;
    else if (searchStart || !modeOk)
      syncState_q <= SYNC_SEARCH;
    else if (lockGain)
      syncState_q <= SYNC_LOCKED;
  end

  // Match run counter used while searching.
  always_ff @(posedge clk_sys)
  begin
    if (srst || searchStart || syncState_q == SYNC_LOCKED)
      matchRun_q <= 6'h00;
    else if (bitStrobe)
      matchRun_q <= mismatch ? 6'h00 : matchRun_q + 6'h01;
  end

  // Error window: restarts every 64 bits while locked.
  always_ff @(posedge clk_sys)
  begin
    if (srst || syncState_q == SYNC_SEARCH)
    begin
      winCnt_q <= 7'h00;
      winErr_q <= 3'h0;
    end
    else if (bitStrobe)
    begin
      if (winCnt_q == ERR_WINDOW - 7'h01)
      begin
        winCnt_q <= 7'h00;
        winErr_q <= 3'h0;
      end
      else
      begin
        winCnt_q <= winCnt_q + 7'h01;
        winErr_q <= winErr_q + {2'h0, mismatch};
      end
    end
  end

  // Pattern phase. While searching a mismatch slips the phase by holding it,
  // and the pseudorandom state reseeds from the line so it predicts the line after seven bits.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      prbs_q <= 7'h7F;
      patPtr_q <= 5'h00;
      wordSel_q <= 1'b0;
      wordRep_q <= 8'h00;
      resyncPrev_q <= 1'b0;
    end
    else
    begin
      resyncPrev_q <= control_q.resync;
      if (bitStrobe)
      begin
        prbs_q <= {prbs_q[5:0], syncState_q == SYNC_LOCKED ? expBit : rxBit};
        if (syncState_q == SYNC_LOCKED || !mismatch)
        begin
          patPtr_q <= patPtr_q + 5'h01;
          if (patPtr_q[3:0] == 4'hF && control_q.patternSelect == PAT_ALTWORD)
          begin
            if (wordRep_q == 8'(ALT_REPEAT - 1))
            begin
              wordRep_q <= 8'h00;
              wordSel_q <= ~wordSel_q;
            end
            else
              wordRep_q <= wordRep_q + 8'h01;
          end
        end
      end
    end
  end

  assign syncLocked = (syncState_q == SYNC_LOCKED);

  ////////////////////////////////////////////////////////////////////////////////
  // Counters and snapshot.

  logic [31:0] bitCnt_q; // Internal received bit count.
  logic [23:0] errCnt_q; // Internal errored bit count.
  logic loadPrev_q; // Previous load strobe.
  wire loadRise = control_q.counterLoadStrobe & ~loadPrev_q;
  wire bitFull = &bitCnt_q;
  wire errFull = &errCnt_q;
  wire errBit = bitStrobe & mismatch; // Counted in or out of lock.
  wire bitOvfSet = bitStrobe & ~bitFull & (bitCnt_q == 32'hFFFFFFFE);
  wire errOvfSet = errBit & ~errFull & (errCnt_q == 24'hFFFFFE);

  // Counters saturate at full scale; a load restarts them, keeping a bit
  // that arrives in the same cycle.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      bitCnt_q <= 32'h00000000;
      errCnt_q <= 24'h000000;
      loadPrev_q <= 1'b0;
    end
    else
    begin
      loadPrev_q <= control_q.counterLoadStrobe;
      if (loadRise)
      begin
        bitCnt_q <= {31'h00000000, bitStrobe};
        errCnt_q <= {23'h000000, errBit};
      end
      else
      begin
        if (bitStrobe && !bitFull)
          bitCnt_q <= bitCnt_q + 32'h00000001;
        if (errBit && !errFull)
          errCnt_q <= errCnt_q + 24'h000001;
      end
    end
  end

  // Host copies change only on a load edge.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      bitSnap_q <= 32'h00000000;
      errSnap_q <= 24'h000000;
    end
    else if (loadRise)
    begin
      bitSnap_q <= bitCnt_q;
      errSnap_q <= errCnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Latched flags. A read clears only the flags it showed, and a new set in the
  // same cycle still wins, so no event slips between capture and clear.

  logic [4:0] zeroRun_q; // Consecutive zeros, saturating at 31.
  logic [4:0] oneRun_q; // Consecutive ones, saturating at 31.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      zeroRun_q <= 5'h00;
      oneRun_q <= 5'h00;
    end
    else if (bitStrobe)
    begin
      zeroRun_q <= rxBit ? 5'h00 : (zeroRun_q == ALL_SAME_RUN ? zeroRun_q : zeroRun_q + 5'h01);
      oneRun_q <= !rxBit ? 5'h00 : (oneRun_q == ALL_SAME_RUN ? oneRun_q : oneRun_q + 5'h01);
    end
  end

  flags_s setEv; // Events that set flags this cycle.
  flags_s clrEv; // Flags a status read may clear.
  always_comb
  begin
    setEv.errOverflow = errOvfSet;
    setEv.bitOverflow = bitOvfSet;
    setEv.bitError = errBit & (syncState_q == SYNC_LOCKED);
    setEv.lossOfLock = searchStart;
    setEv.allZeros = (zeroRun_q == ALL_SAME_RUN);
    setEv.allOnes = (oneRun_q == ALL_SAME_RUN);
    clrEv = statusRead ? flags_s'(readMask_q) : flags_s'(6'h00);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      flags_q <= flags_s'(6'h00);
    else
      flags_q <= flags_s'((flags_q & ~clrEv) | setEv);
  end

  // Lock changes latch for the event request.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      lockChange_q <= 1'b0;
    else
      lockChange_q <= (lockChange_q & ~statusRead) | lockGain | lockLose;
  end

  // Event request, enabled per class of event.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      testerAlert <= 1'b0;
    else
      testerAlert <= (control_q.overflowIrqEnable & (flags_q.errOverflow | flags_q.bitOverflow))
        | (control_q.bitErrorIrqEnable & flags_q.bitError)
        | (control_q.lockChangeIrqEnable & lockChange_q);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path, captured in the setup cycle.

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      prdata_q <= 32'h00000000;
      readMask_q <= 6'h00;
    end
    else if (setupPhase)
    begin
      readMask_q <= flags_q;
      case (paddr)
        ADDR_CONTROL: prdata_q <= {16'h0000, control_q};
        ADDR_PAT_LOW: prdata_q <= {16'h0000, pattern_q[15:0]};
        ADDR_PAT_HIGH: prdata_q <= {16'h0000, pattern_q[31:16]};
        ADDR_BIT_LOW: prdata_q <= {16'h0000, bitSnap_q[15:0]};
        ADDR_BIT_HIGH: prdata_q <= {16'h0000, bitSnap_q[31:16]};
        ADDR_ERR_STATUS: prdata_q <= {16'h0000, errSnap_q[7:0], 1'b0, flags_q,
          syncLocked};
        ADDR_ERR_HIGH: prdata_q <= {16'h0000, errSnap_q[23:8]};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence lockRun;
    (bitStrobe && syncState_q == SYNC_SEARCH && !mismatch && modeOk);
  endsequence

  AST_LOCK_NEEDS_RUN: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(syncLocked) |-> $past(matchRun_q) == LOCK_RUN - 6'h01)
    else $error("Lock gained without 32 matches.");
  AST_LOCK_AFTER_RUN: assert property (@(posedge clk_sys) disable iff (srst)
    lockRun ##0 (matchRun_q == 6'h1F && !resyncRise) |=> syncLocked)
    else $error("Lock not gained after 32 matches.");
  AST_UNLOCK_SIX: assert property (@(posedge clk_sys) disable iff (srst)
    lockLose |=> !syncLocked && flags_q.lossOfLock)
    else $error("Six window errors did not drop lock.");
  AST_BIT_COUNT: assert property (@(posedge clk_sys) disable iff (srst)
    bitStrobe && !loadRise && !bitFull |=> bitCnt_q == $past(bitCnt_q) + 32'h00000001)
    else $error("Bit counter did not advance.");
  AST_BIT_SAT: assert property (@(posedge clk_sys) disable iff (srst)
    bitFull && !loadRise |=> bitFull)
    else $error("Bit counter wrapped.");
  AST_ERR_SAT: assert property (@(posedge clk_sys) disable iff (srst)
    errOvfSet && !loadRise |=> errFull && flags_q.errOverflow)
    else $error("Error counter overflow not flagged.");
  AST_SNAPSHOT: assert property (@(posedge clk_sys) disable iff (srst)
    loadRise |=> bitSnap_q == $past(bitCnt_q) && errSnap_q == $past(errCnt_q)
      && bitCnt_q <= 32'h00000001)
    else $error("Load edge did not snapshot and restart counts.");
  AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (srst)
    statusRead && setEv.bitError |=> flags_q.bitError)
    else $error("Bit error lost under a clearing read.");
  AST_BED_LOCKED: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(flags_q.bitError) |-> $past(syncState_q) == SYNC_LOCKED)
    else $error("Bit error flagged while out of lock.");
  AST_ZERO_RUN: assert property (@(posedge clk_sys) disable iff (srst)
    zeroRun_q == ALL_SAME_RUN |=> flags_q.allZeros)
    else $error("All zeros flag missing.");

endmodule : bert_pattern_counters_status

//--- testbench/bert_link_model.sv
// Bit stream source that stands in for the assigned port or channel.
`timescale 1ns/1ps

module bert_link_model (
  // Burst request from the bench.
  input wire logic go,
  input wire logic [15:0] count,
  input wire logic [31:0] word,
  input wire logic [31:0] flip,
  // High to send the seven stage pseudorandom sequence instead of the word.
  input wire logic prbs,
  // Serial bit stream towards the tester.
  output logic rxClk,
  output logic rxData,
  // High while a burst is being sent.
  output logic busy
);
  // Position in the 32-bit word; it runs on across bursts so the stream stays continuous.
  int pos = 0;
  // Pseudorandom state with the newest bit in bit 0, and the bit it makes next.
  logic [6:0] gen = 7'h7F;
  logic nb;

  ////////////////////////////////////////////////////////////////////////////////
  // The clock stands still between bursts; the odd offset keeps its edges off clk_sys edges.
  initial
  begin
    rxClk = 1'b0;
    rxData = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge go);
      busy = 1'b1;
      #137;
      for (int i = 0; i < count; i++)
      begin
        nb = gen[6] ^ gen[5];
        if (prbs)
        begin
          gen = {gen[5:0], nb};
          rxData = nb ^ flip[pos];
        end
        else
          rxData = word[pos] ^ flip[pos];
        #400 rxClk = 1'b1;
        #400 rxClk = 1'b0;
        pos = (pos + 1) % 32;
      end
      // A released data line shows the inverse, never the last valid bit.
      rxData = ~rxData;
      busy = 1'b0;
    end
  end
endmodule : bert_link_model

//--- testbench/tb_top.sv
// Self-checking bench for the pattern tester counters and status registers.
`timescale 1ns/1ps

module tb_top;
  import bert_pkg::*;

  // Clock, reset and bus signals, all defined from time zero.
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Link and burst control.
  logic rxClk;
  logic rxData;
  logic go = 1'b0;
  logic prbs = 1'b0;
  logic busy;
  logic [15:0] count = 16'h0000;
  logic [31:0] word = 32'h0000_0000;
  logic [31:0] flip = 32'h0000_0000;
  // Observed outputs and bench bookkeeping.
  logic testerAlert;
  logic syncLocked;
  logic lastErr;
  logic [31:0] rdv;
  logic [15:0] ctrlQ;
  int errors = 0;
  int checks = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Design and link source.
  bert_pattern_counters_status #(.ALT_REPEAT(1)) bert_pattern_counters_status_i (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxClk(rxClk), .rxData(rxData), .testerAlert(testerAlert), .syncLocked(syncLocked)
  );
  bert_link_model bert_link_model_i (
    .go(go), .count(count), .word(word), .flip(flip), .prbs(prbs),
    .rxClk(rxClk), .rxData(rxData), .busy(busy)
  );

  // The 10 MHz system clock.
  always #50 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare one value and count the result.
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high at an edge.
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 100)
      errors++;
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Write helper that drops the read data.
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(a, 1'b1, d, dummy);
  endtask : wr

  // Read a register and compare it under a mask.
  task rdc(input string name, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0000_0000, rdv);
    chk(name, e, rdv & m);
  endtask : rdc

  // Pick a pattern, let the select settle at least 64 cycles, then raise resync.
  task set_sel(input logic [2:0] s);
    ctrlQ = 16'h4F00 | {11'h000, s, 2'b00};
    wr(ADDR_CONTROL, {16'h0000, ctrlQ});
    repeat (70) @(posedge clk_sys);
    ctrlQ = ctrlQ | 16'h0001;
    wr(ADDR_CONTROL, {16'h0000, ctrlQ});
  endtask : set_sel

  // Rising load strobe, then low again so the next load is a fresh edge.
  task load_counts();
    wr(ADDR_CONTROL, {16'h0000, ctrlQ | 16'h0002});
    wr(ADDR_CONTROL, {16'h0000, ctrlQ});
  endtask : load_counts

  // Send a burst and wait for it to finish, bounded.
  task send(input int n, input logic [31:0] w, input logic [31:0] f);
    int k;
    word <= w;
    flip <= f;
    count <= n[15:0];
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 2000)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 2000)
      errors++;
    // Let the two sync flops and the counters catch the last bit.
    repeat (8) @(posedge clk_sys);
  endtask : send

  // Print the counts and the verdict, then stop.
  task wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  // A hang counts as a mismatch and ends the run the usual way.
  initial
  begin
    #3000000;
    errors++;
    wrap_up();
  end

  // Main test sequence.
  initial
  begin
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    // Reset values, read-only counters and an unmapped address.
    wr(ADDR_BIT_LOW, 32'h0000_FFFF);
    rdc("bit_low", ADDR_BIT_LOW, 32'hFFFF_FFFF, 32'h0);
    rdc("bit_high", ADDR_BIT_HIGH, 32'hFFFF_FFFF, 32'h0);
    rdc("err_status", ADDR_ERR_STATUS, 32'hFFFF_FFFF, 32'h0);
    rdc("err_high", ADDR_ERR_HIGH, 32'hFFFF_FFFF, 32'h0);
    rdc("unmapped", 12'h520, 32'hFFFF_FFFF, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, lastErr});
    chk("alert_idle", 32'h0, {31'h0, testerAlert});
    // Pattern store is loaded first and reads back in the low half only.
    wr(ADDR_PAT_LOW, 32'hDEAD_1E77);
    wr(ADDR_PAT_HIGH, 32'hBEEF_A5C3);
    rdc("pat_low", ADDR_PAT_LOW, 32'hFFFF_FFFF, 32'h0000_1E77);
    rdc("pat_high", ADDR_PAT_HIGH, 32'hFFFF_FFFF, 32'h0000_A5C3);
    // Lock on a 32-bit repetitive pattern sent low bit first.
    set_sel(PAT_REPEAT);
    send(64, 32'hA5C3_1E77, 32'h0);
    chk("lock_rep", 32'h1, {31'h0, syncLocked});
    rdc("status_lock", ADDR_ERR_STATUS, 32'h1F, 32'h11);
    rdc("status_reread", ADDR_ERR_STATUS, 32'h1F, 32'h01);
    load_counts();
    rdc("bits_64", ADDR_BIT_LOW, 32'hFFFF_FFFF, 32'd64);
    // Four spaced errors stay in lock and are counted from a fresh period.
    send(64, 32'hA5C3_1E77, 32'h0001_0001);
    chk("alert_bed", 32'h1, {31'h0, testerAlert});
    load_counts();
    rdc("bits_new", ADDR_BIT_LOW, 32'hFFFF_FFFF, 32'd64);
    rdc("err_bed", ADDR_ERR_STATUS, 32'hFF0F, 32'h0409);
    rdc("err_hi", ADDR_ERR_HIGH, 32'hFFFF_FFFF, 32'h0);
    rdc("bed_clear", ADDR_ERR_STATUS, 32'h0F, 32'h01);
    chk("alert_clear", 32'h0, {31'h0, testerAlert});
    // A run of inverted bits drops lock; counting goes on while out of lock.
    send(32, 32'hA5C3_1E77, 32'hFFFF_FFFF);
    chk("lock_lost", 32'h0, {31'h0, syncLocked});
    rdc("status_los", ADDR_ERR_STATUS, 32'h11, 32'h10);
    // The hunt slips one position per mismatch, so relock needs more than 64 bits.
    send(128, 32'hA5C3_1E77, 32'h0);
    chk("relock", 32'h1, {31'h0, syncLocked});
    load_counts();
    rdc("bits_160", ADDR_BIT_LOW, 32'hFFFF_FFFF, 32'd160);
    rdc("bits_160_hi", ADDR_BIT_HIGH, 32'hFFFF_FFFF, 32'h0);
    // Alternating words: lower half first, then upper half.
    wr(ADDR_PAT_LOW, 32'h0000_0000);
    wr(ADDR_PAT_HIGH, 32'h0000_7E7E);
    set_sel(PAT_ALTWORD);
    send(64, 32'h7E7E_0000, 32'h0);
    chk("lock_alt", 32'h1, {31'h0, syncLocked});
    // Pseudorandom mode with the store set to all ones locks on the line sequence.
    wr(ADDR_PAT_LOW, 32'h0000_FFFF);
    wr(ADDR_PAT_HIGH, 32'h0000_FFFF);
    set_sel(PAT_PRBS7);
    prbs <= 1'b1;
    send(64, 32'h0, 32'h0);
    chk("lock_prbs", 32'h1, {31'h0, syncLocked});
    prbs <= 1'b0;
    // Illegal select codes never lock.
    set_sel(PAT_ILL6);
    send(64, 32'h7E7E_0000, 32'h0);
    chk("lock_ill6", 32'h0, {31'h0, syncLocked});
    set_sel(PAT_ILL7);
    send(64, 32'h7E7E_0000, 32'h0);
    chk("lock_ill7", 32'h0, {31'h0, syncLocked});
    // Runs of 30 and 31 equal bits around the all-ones and all-zeros thresholds.
    send(30, 32'hFFFF_FFFF, 32'h0);
    rdc("ones_30", ADDR_ERR_STATUS, 32'h40, 32'h00);
    send(1, 32'hFFFF_FFFF, 32'h0);
    rdc("ones_31", ADDR_ERR_STATUS, 32'h40, 32'h40);
    send(30, 32'h0, 32'h0);
    rdc("zeros_30", ADDR_ERR_STATUS, 32'h60, 32'h40);
    send(1, 32'h0, 32'h0);
    rdc("zeros_31", ADDR_ERR_STATUS, 32'h60, 32'h20);
    wrap_up();
  end
endmodule : tb_top
